// ---- hw/pcs_am_pkg.sv ----
/*
 * Shared constants, carrier types and helper functions for the lane marker
 * inserter. Assumes 66-bit words with bit 0 sent first and sync in bits 1:0.
 */
package pcs_am_pkg;

	// ----------------------------------------------------------------
	// Sizes and timing counts
	// ----------------------------------------------------------------
	localparam int BLOCK_W = 66;
	localparam int MAX_LANES = 20;
	localparam int LANES_40G = 4;
	localparam int LANES_100G = 20;
	localparam int AM_PERIOD = 16384;
	localparam int FIFO_DEPTH = 16;
	localparam int OWED_W = 8;
	localparam logic [6:0] BIT_LAST = 7'h41;
	localparam logic [1:0] SYNC_CTRL = 2'h1;

	// ----------------------------------------------------------------
	// Field positions inside a marker word
	// ----------------------------------------------------------------
	localparam int MK_CODE_LO = 2;
	localparam int MK_PAR_LO = 26;
	localparam int MK_INV_LO = 34;
	localparam int MK_IPAR_LO = 58;

	// ----------------------------------------------------------------
	// Carrier and state types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [BLOCK_W-1:0] word;
		logic deletable;
	} block_in_t;

	typedef enum logic [0:0] {
		FILL_LOAD = 1'b0,
		FILL_WAIT = 1'b1
	} fill_state_t;

	// Marker code {marker_octet_zero, M1, M2} per lane and rate
	function automatic logic [23:0] marker_code(input logic m100, input logic [4:0] lane);
		logic [23:0] c;
		c = 24'h000000;
		if (m100) begin
			case (lane)
				5'h00: c = 24'hC16821;
				5'h01: c = 24'h9D718E;
				5'h02: c = 24'h594BE8;
				5'h03: c = 24'h4D957B;
				5'h04: c = 24'hF50709;
				5'h05: c = 24'hDD14C2;
				5'h06: c = 24'h9A4A26;
				5'h07: c = 24'h7B4566;
				5'h08: c = 24'hA02476;
				5'h09: c = 24'h68C9FB;
				5'h0A: c = 24'hFD6C99;
				5'h0B: c = 24'hB99155;
				5'h0C: c = 24'h5CB9B2;
				5'h0D: c = 24'h1AF8BD;
				5'h0E: c = 24'h83C7CA;
				5'h0F: c = 24'h3536CD;
				5'h10: c = 24'hC4314C;
				5'h11: c = 24'hADD6B7;
				5'h12: c = 24'h5F662A;
				5'h13: c = 24'hC0F0E5;
				default: c = 24'h000000;
			endcase
		end else begin
			case (lane)
				5'h00: c = 24'h907647;
				5'h01: c = 24'hF0C4E6;
				5'h02: c = 24'hC5659B;
				5'h03: c = 24'hA2793D;
				default: c = 24'h000000;
			endcase
		end
		return c;
	endfunction

	// Marker word with the parity fields still zero, bit 0 sent first
	function automatic logic [BLOCK_W-1:0] marker_word(input logic m100, input logic [4:0] lane);
		logic [23:0] c;
		c = marker_code(m100, lane);
		return {8'h00, ~c[7:0], ~c[15:8], ~c[23:16], 8'h00, c[7:0], c[15:8], c[23:16], SYNC_CTRL};
	endfunction

	// Interleaved even parity of one word, sync bits folded into bits 3 and 4
	function automatic logic [7:0] word_parity(input logic [BLOCK_W-1:0] w);
		logic [7:0] p;
		p = 8'h00;
		for (int n = 0; n < 8; n++) begin
			for (int k = 0; k < 8; k++) begin
				p[n] = p[n] ^ w[2 + n + 8 * k];
			end
		end
		p[3] = p[3] ^ w[0];
		p[4] = p[4] ^ w[1];
		return p;
	endfunction

endpackage

// ---- hw/block_fifo.sv ----
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock, a synchronous active-high reset and a freezing enable.
 */
`timescale 1ns/1ps
module block_fifo #(
	parameter int WIDTH = 67,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	// ----------------------------------------------------------------
	// Pointers and fill level
	// ----------------------------------------------------------------
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule

// ---- hw/pcs_lane_marker_insertion.sv ----
/*
 * Transmit lane distribution with periodic alignment marker insertion.
 * Assumes encoded, scrambled blocks arrive on the same clock, flagged
 * where they are idle or sequence content that may be dropped.
 */
`timescale 1ns/1ps

// Behaviour
// - One marker per 16383 ordinary blocks per lane
// - Marker carries control sync and eight octets
// - Markers share one slot, preempting data
// - Gap content dropped to recover marker bandwidth
// - Twenty fixed marker codes at 100G
// - Four fixed marker codes at 40G
// - Octets four to six complement zero to two
// - Last octet complements parity octet
// - Octets LSB first, sync bits first
// - Even parity since previous marker inclusive
// - Parity bit n covers positions 2+n step 8
// - Parity bits 3,4 add sync bits
// - Parity octets sent LSB first
// - Parity only reported, steers no control
// - One serial stream per lane
// - Consecutive groups on successive lanes
// - After lane 19, or lane 3 at 40G, wrap to lane 0
// - Round robin over 4 or 20 lanes
// - Drop idles so markers never overflow
module pcs_lane_marker_insertion #(
	parameter int AM_PERIOD = pcs_am_pkg::AM_PERIOD,
	parameter int FIFO_DEPTH = pcs_am_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic mode_100g,
	input pcs_am_pkg::block_in_t in_block,
	input wire logic in_valid,
	output logic in_ready,
	output logic [pcs_am_pkg::MAX_LANES-1:0] lane_bit,
	output logic [pcs_am_pkg::MAX_LANES-1:0] lane_bit_valid,
	output logic [pcs_am_pkg::MAX_LANES-1:0][7:0] lane_parity_octet,
	output logic [pcs_am_pkg::MAX_LANES-1:0] lane_parity_strobe
);
	localparam int NL = pcs_am_pkg::MAX_LANES;
	localparam int BW = pcs_am_pkg::BLOCK_W;
	localparam int SW = $clog2(AM_PERIOD);

	logic m100;
	logic [4:0] lanes;
	logic [6:0] bit_cnt, next_bit_cnt;
	logic [SW-1:0] slot, next_slot;
	logic [4:0] coding_lane_index, next_coding_lane_index;
	pcs_am_pkg::fill_state_t state, next_state;
	logic [BW-1:0] hold [NL];
	logic [BW-1:0] next_hold [NL];
	logic [BW-1:0] shift [NL];
	logic [BW-1:0] next_shift [NL];
	logic [7:0] acc [NL];
	logic [7:0] next_acc [NL];
	logic [NL-1:0] hold_full, next_hold_full, hold_mark, next_hold_mark;
	logic [NL-1:0] next_lane_bit_valid, next_parity_strobe;
	logic [NL-1:0][7:0] next_parity_octet;
	logic [pcs_am_pkg::OWED_W-1:0] owed, next_owed;
	logic transfer, load_fire, pop, drop, marking;
	pcs_am_pkg::block_in_t fifo_out;
	logic fifo_valid, fifo_in_ready;

	// ----------------------------------------------------------------
	// Mode capture and input buffering with gap deletion
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			m100 <= mode_100g;
		end
	end

	assign lanes = m100 ? 5'(pcs_am_pkg::LANES_100G) : 5'(pcs_am_pkg::LANES_40G);
	assign drop = in_valid && in_block.deletable && (owed != '0);
	assign in_ready = drop || fifo_in_ready;

	block_fifo #(
		.WIDTH($bits(pcs_am_pkg::block_in_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.in_data(in_block),
		.in_valid(in_valid && !drop),
		.in_ready(fifo_in_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	// ----------------------------------------------------------------
	// Fill, distribute, serialise and parity
	// ----------------------------------------------------------------
	assign transfer = (bit_cnt == pcs_am_pkg::BIT_LAST);
	assign marking = (slot == '0);
	assign load_fire = !transfer && (state == pcs_am_pkg::FILL_LOAD) && (marking || fifo_valid);
	assign pop = load_fire && !marking;

	always_comb begin
		logic [BW-1:0] w;
		logic [7:0] p;
		w = '0;
		p = '0;
		next_bit_cnt = bit_cnt;
		next_slot = slot;
		next_coding_lane_index = coding_lane_index;
		next_state = state;
		next_hold_full = hold_full;
		next_hold_mark = hold_mark;
		next_lane_bit_valid = lane_bit_valid;
		next_parity_strobe = '0;
		next_parity_octet = lane_parity_octet;
		next_owed = owed - pcs_am_pkg::OWED_W'(drop);
		for (int i = 0; i < NL; i++) begin
			next_hold[i] = hold[i];
			next_shift[i] = shift[i] >> 1;
			next_acc[i] = acc[i];
		end
		if (transfer) begin
			next_bit_cnt = '0;
			next_coding_lane_index = '0;
			next_state = pcs_am_pkg::FILL_LOAD;
			next_hold_full = '0;
			next_hold_mark = '0;
			next_slot = (slot == SW'(AM_PERIOD - 1)) ? '0 : slot + SW'(1);
			if (slot == SW'(AM_PERIOD - 1)) begin
				next_owed = next_owed + pcs_am_pkg::OWED_W'(lanes);
			end
			next_lane_bit_valid = hold_full;
			for (int i = 0; i < NL; i++) begin
				w = hold[i];
				if (hold_mark[i]) begin
					w[pcs_am_pkg::MK_PAR_LO +: 8] = acc[i];
					w[pcs_am_pkg::MK_IPAR_LO +: 8] = ~acc[i];
					next_parity_octet[i] = acc[i];
					next_parity_strobe[i] = 1'b1;
				end
				p = pcs_am_pkg::word_parity(w);
				if (hold_full[i]) begin
					next_acc[i] = hold_mark[i] ? p : acc[i] ^ p;
				end
				next_shift[i] = w;
			end
		end else begin
			next_bit_cnt = bit_cnt + 7'h01;
			if (load_fire) begin
				if (marking) begin
					next_hold[coding_lane_index] = pcs_am_pkg::marker_word(m100, coding_lane_index);
					next_hold_mark[coding_lane_index] = 1'b1;
				end else begin
					next_hold[coding_lane_index] = fifo_out.word;
				end
				next_hold_full[coding_lane_index] = 1'b1;
				next_coding_lane_index = coding_lane_index + 5'h01;
				if (coding_lane_index + 5'h01 == lanes) begin
					next_state = pcs_am_pkg::FILL_WAIT;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_cnt <= '0;
			slot <= '0;
			coding_lane_index <= '0;
			state <= pcs_am_pkg::FILL_LOAD;
			hold_full <= '0;
			hold_mark <= '0;
			lane_bit_valid <= '0;
			lane_parity_strobe <= '0;
			lane_parity_octet <= '0;
			owed <= '0;
			for (int i = 0; i < NL; i++) begin
				hold[i] <= '0;
				shift[i] <= '0;
				acc[i] <= '0;
			end
		end else if (ce) begin
			bit_cnt <= next_bit_cnt;
			slot <= next_slot;
			coding_lane_index <= next_coding_lane_index;
			state <= next_state;
			hold_full <= next_hold_full;
			hold_mark <= next_hold_mark;
			lane_bit_valid <= next_lane_bit_valid;
			lane_parity_strobe <= next_parity_strobe;
			lane_parity_octet <= next_parity_octet;
			owed <= next_owed;
			for (int i = 0; i < NL; i++) begin
				hold[i] <= next_hold[i];
				shift[i] <= next_shift[i];
				acc[i] <= next_acc[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NL; i++) begin
			lane_bit[i] = shift[i][0];
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence mark_sent;
		ce && transfer && hold_mark[0] && hold_full[0];
	endsequence

	sequence data_round_end;
		ce && transfer && (slot == SW'(AM_PERIOD - 1)) && !drop;
	endsequence

	sequence data_load;
		ce && load_fire && !marking;
	endsequence

	a_period_wrap: assert property (@(posedge clk) disable iff (sys_rst)
		ce && transfer && (slot == SW'(AM_PERIOD - 1)) |=> marking)
		else $error("period counter did not return to the marker slot");

	a_marker_header: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent |=> shift[0][1:0] == pcs_am_pkg::SYNC_CTRL)
		else $error("marker sync header wrong");

	a_all_lanes_marked: assert property (@(posedge clk) disable iff (sys_rst)
		ce && transfer && marking |-> (hold_mark == hold_full))
		else $error("marker slot carried a data block");

	a_inverted_code: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent |=> shift[0][57:34] == ~shift[0][25:2])
		else $error("marker octets four to six not inverted");

	a_inverted_parity: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent |=> shift[0][65:58] == ~shift[0][33:26])
		else $error("last marker octet not the inverted parity");

	a_sync_bits_first: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent ##1 ce |-> lane_bit[0] ##1 !lane_bit[0])
		else $error("marker sync bits not sent first");

	a_parity_restart: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent |=> acc[0] == pcs_am_pkg::word_parity(shift[0]))
		else $error("parity did not restart on the marker word");

	a_round_robin: assert property (@(posedge clk) disable iff (sys_rst)
		ce && load_fire |=> coding_lane_index == $past(coding_lane_index) + 5'h01)
		else $error("lane selection skipped a lane");

	a_lane_bound: assert property (@(posedge clk) disable iff (sys_rst)
		coding_lane_index <= lanes)
		else $error("lane index beyond active lanes");

	a_credit_grant: assert property (@(posedge clk) disable iff (sys_rst)
		data_round_end |=> owed == $past(owed) + pcs_am_pkg::OWED_W'(lanes))
		else $error("marker bandwidth credit not granted");

	a_parity_report: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent |=> (lane_parity_octet[0] == shift[0][33:26]) && lane_parity_strobe[0])
		else $error("parity report differs from the sent parity octet");

	a_strobe_marker_only: assert property (@(posedge clk) disable iff (sys_rst)
		ce && transfer && !hold_mark[0] |=> !lane_parity_strobe[0])
		else $error("parity strobe without a marker");

	a_valid_groups: assert property (@(posedge clk) disable iff (sys_rst)
		ce && transfer |=> lane_bit_valid == $past(hold_full))
		else $error("lane valid does not follow the loaded groups");

	a_idle_lanes_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		!m100 |-> lane_bit_valid[NL-1:pcs_am_pkg::LANES_40G] == '0)
		else $error("lane beyond the 40G set carried a group");

	a_marker_lanes_full: assert property (@(posedge clk) disable iff (sys_rst)
		ce && transfer && marking |-> hold_full[0] && (coding_lane_index == lanes))
		else $error("marker slot left an active lane empty");

	a_credit_spend: assert property (@(posedge clk) disable iff (sys_rst)
		ce && drop && !(transfer && (slot == SW'(AM_PERIOD - 1))) |=>
			owed == $past(owed) - pcs_am_pkg::OWED_W'(1))
		else $error("dropped block did not spend credit");

	a_wrap_to_zero: assert property (@(posedge clk) disable iff (sys_rst)
		ce && transfer |=> coding_lane_index == 5'h00)
		else $error("lane selection did not wrap to lane 0");

	a_data_pass: assert property (@(posedge clk) disable iff (sys_rst)
		data_load ##0 (coding_lane_index == 5'h00) |=> hold[0] == $past(fifo_out.word))
		else $error("data block altered on its way to the lane");

	a_code_100g: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent ##0 m100 |=> shift[0][25:2] == {8'h21, 8'h68, 8'hC1})
		else $error("lane 0 marker code wrong at 100G");

	a_code_40g: assert property (@(posedge clk) disable iff (sys_rst)
		mark_sent ##0 !m100 |=> shift[0][25:2] == {8'h47, 8'h76, 8'h90})
		else $error("lane 0 marker code wrong at 40G");
endmodule

// ---- bench/pma_lane_sink.sv ----
/*
 * Far-side model: rebuilds each lane's 66-bit groups, first bit into bit 0.
 * Assumes one bit per lane per enabled clock while that lane is valid.
 */
`timescale 1ns/1ps
module pma_lane_sink (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [pcs_am_pkg::MAX_LANES-1:0] lane_bit,
	input wire logic [pcs_am_pkg::MAX_LANES-1:0] lane_bit_valid
);
	logic [65:0] sh [20];
	int cnt [20];
	logic [65:0] q [20][$];

	always @(posedge clk) begin
		for (int l = 0; l < 20; l++) begin
			if (sys_rst) begin
				cnt[l] = 0;
				q[l].delete();
			end else if (ce && lane_bit_valid[l]) begin
				sh[l] = {lane_bit[l], sh[l][65:1]};
				cnt[l] = cnt[l] + 1;
				if (cnt[l] == 66) begin
					q[l].push_back(sh[l]);
					cnt[l] = 0;
				end
			end
		end
	end
endmodule

// ---- bench/tb_pcs_lane_marker_insertion.sv ----
/*
 * Self-checking bench for the lane marker inserter.
 * Assumes a short marker period of 8 slots and the far-side sink model.
 */
`timescale 1ns/1ps
module tb_pcs_lane_marker_insertion;
	// ----------------------------------------------------------------
	// Signals and expected marker codes
	// ----------------------------------------------------------------
	logic clk;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic mode_100g = 1'b0;
	logic in_valid = 1'b0;
	logic in_ready;
	pcs_am_pkg::block_in_t in_block = '0;
	logic [19:0] lane_bit, lane_bit_valid, lane_parity_strobe;
	logic [19:0][7:0] lane_parity_octet;
	int n_errors = 0;
	int n_checks = 0;
	int stalls = 0;
	int rc = 0;
	logic [7:0] par [20];
	int n_strobe [20];
	logic [23:0] codes [24] = '{24'h907647, 24'hF0C4E6, 24'hC5659B, 24'hA2793D,
		24'hC16821, 24'h9D718E, 24'h594BE8, 24'h4D957B, 24'hF50709, 24'hDD14C2,
		24'h9A4A26, 24'h7B4566, 24'hA02476, 24'h68C9FB, 24'hFD6C99, 24'hB99155,
		24'h5CB9B2, 24'h1AF8BD, 24'h83C7CA, 24'h3536CD, 24'hC4314C, 24'hADD6B7,
		24'h5F662A, 24'hC0F0E5};

	pcs_lane_marker_insertion #(.AM_PERIOD(8), .FIFO_DEPTH(16)) pcs_lane_marker_insertion_i (
		.clk(clk), .sys_rst(sys_rst), .ce(ce), .mode_100g(mode_100g),
		.in_block(in_block), .in_valid(in_valid), .in_ready(in_ready),
		.lane_bit(lane_bit), .lane_bit_valid(lane_bit_valid),
		.lane_parity_octet(lane_parity_octet), .lane_parity_strobe(lane_parity_strobe)
	);

	pma_lane_sink pma_lane_sink_i (
		.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.lane_bit(lane_bit), .lane_bit_valid(lane_bit_valid)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(posedge clk) begin
		rc <= sys_rst ? 0 : rc + 1;
		for (int l = 0; l < 20; l++) begin
			if (sys_rst) n_strobe[l] <= 0;
			else if (ce && lane_parity_strobe[l]) n_strobe[l] <= n_strobe[l] + 1;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [65:0] dw(input int i);
		return {32'(i) * 32'h9E3779B1, 32'(i) * 32'h85EBCA77 + 32'h1234, 2'h2};
	endfunction

	function automatic logic [65:0] mk(input logic [23:0] c, input logic [7:0] p);
		return {~p, ~c[7:0], ~c[15:8], ~c[23:16], p, c[7:0], c[15:8], c[23:16], 2'h1};
	endfunction

	function automatic logic [7:0] bip(input logic [65:0] w);
		logic [7:0] p;
		p = 8'h00;
		for (int n = 0; n < 8; n++) begin
			for (int k = 0; k < 8; k++) p[n] ^= w[2 + n + 8 * k];
		end
		p[3] ^= w[0];
		p[4] ^= w[1];
		return p;
	endfunction

	task automatic err(input string s);
		n_errors++;
		$display("MISMATCH t=%0t %s", $time, s);
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic m);
		sys_rst = 1'b1;
		mode_100g = m;
		in_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		for (int l = 0; l < 20; l++) par[l] = 8'h00;
	endtask

	task automatic push(input int i, input logic del);
		int g;
		in_block = '{word: dw(i), deletable: del};
		in_valid = 1'b1;
		g = 0;
		while (in_ready !== 1'b1 && g < 2000) begin
			stalls++;
			@(posedge clk);
			#1;
			g++;
		end
		if (g >= 2000) err("block never accepted");
		@(posedge clk);
		#1;
	endtask

	task automatic wait_all(input int lanes, input int n);
		int g;
		g = 0;
		for (int l = 0; l < lanes; l++) begin
			while (pma_lane_sink_i.q[l].size() < n && g < 5000) begin
				@(posedge clk);
				g++;
			end
		end
		if (g >= 5000) err("lane groups missing");
		#1;
	endtask

	task automatic chk_strobes(input int nl, input int n);
		for (int l = 0; l < 20; l++) begin
			n_checks++;
			if (n_strobe[l] != ((l < nl) ? n : 0)) err($sformatf("lane %0d strobes", l));
		end
	endtask

	task automatic chk_word(input int l, input int idx, input logic [65:0] e);
		n_checks++;
		if (pma_lane_sink_i.q[l].size() <= idx || pma_lane_sink_i.q[l][idx] !== e) begin
			err($sformatf("lane %0d group %0d", l, idx));
		end
	endtask

	task automatic chk_data(input int l, input int idx, input int i);
		chk_word(l, idx, dw(i));
		par[l] ^= bip(dw(i));
	endtask

	task automatic chk_marker(input int l, input int idx, input logic [23:0] c, input bit rep);
		logic [65:0] e;
		e = mk(c, par[l]);
		chk_word(l, idx, e);
		if (rep) begin
			n_checks++;
			if (lane_parity_octet[l] !== par[l]) err($sformatf("lane %0d parity report", l));
		end
		par[l] = bip(e);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_40g();
		do_reset(1'b0);
		for (int i = 0; i < 28; i++) push(i, 1'b0);
		in_valid = 1'b0;
		wait_all(4, 9);
		n_checks++;
		if (stalls == 0) err("buffer never refused");
		for (int l = 0; l < 4; l++) begin
			chk_marker(l, 0, codes[l], 1'b0);
			for (int r = 1; r < 8; r++) chk_data(l, r, 4 * (r - 1) + l);
			chk_marker(l, 8, codes[l], 1'b1);
		end
		for (int l = 4; l < 20; l++) begin
			n_checks++;
			if (pma_lane_sink_i.q[l].size() != 0) err("unused lane carried data");
		end
		chk_strobes(4, 2);
		$display("test t_40g done");
	endtask

	task automatic t_drop();
		logic [39:0] sv;
		while (rc % 66 != 21) @(posedge clk);
		#1;
		for (int i = 0; i < 5; i++) push(100 + i, 1'b1);
		for (int i = 0; i < 7; i++) push(200 + i, 1'b0);
		in_valid = 1'b0;
		while (lane_bit_valid[0] !== 1'b1) @(posedge clk);
		repeat (3) @(posedge clk);
		#1;
		ce = 1'b0;
		sv = {lane_bit, lane_bit_valid};
		repeat (5) @(posedge clk);
		#1;
		n_checks++;
		if ({lane_bit, lane_bit_valid} !== sv) err("lanes moved while disabled");
		ce = 1'b1;
		wait_all(4, 12);
		chk_data(0, 9, 104);
		for (int l = 1; l < 4; l++) chk_data(l, 9, 199 + l);
		for (int l = 0; l < 4; l++) chk_data(l, 10, 203 + l);
		for (int l = 0; l < 4; l++) chk_marker(l, 11, codes[l], 1'b1);
		chk_strobes(4, 3);
		$display("test t_drop done");
	endtask

	task automatic t_100g();
		do_reset(1'b1);
		for (int i = 0; i < 40; i++) push(i, 1'b0);
		in_valid = 1'b0;
		wait_all(20, 4);
		for (int l = 0; l < 20; l++) begin
			chk_marker(l, 0, codes[4 + l], 1'b0);
			chk_data(l, 1, l);
			chk_data(l, 2, 20 + l);
			chk_marker(l, 3, codes[4 + l], 1'b1);
		end
		chk_strobes(20, 2);
		$display("test t_100g done");
	endtask

	initial begin
		t_40g();
		t_drop();
		t_100g();
		finish_test();
	end

	initial begin
		#40000;
		err("watchdog expired");
		finish_test();
	end
endmodule
